// ---- test_usb_host_operational_regs.sv ----
/*
 * Self-checking bench for the register bank, driven through the host model.
 * Assumes a 4 KB window per function and three distinct window bases.
 */
`timescale 1ns/10ps
module test_usb_host_operational_regs
	import uhr_pkg::*;
;
	localparam int unsigned WB = 12;
	logic CORE_CLK = 1'b0;
	logic NRST = 1'b0;
	logic [6:0] OHCI0_EVENT = 7'h0;
	logic [6:0] OHCI1_EVENT = 7'h0;
	logic [5:0] EHCI_EVENT = 6'h0;
	logic [31:0] BUS_ADDR, BUS_WDATA, BUS_RDATA;
	logic [3:0] BUS_BE;
	logic [1:0] CFG_FUNC;
	logic BUS_WR, BUS_RD, CFG_WR, CFG_RD, BUS_ACK, EHCI_RUN, EHCI_CONFIGURED;
	logic [31:0] bases[4] = '{32'h1000_0000, 32'h1000_1000, 32'h1000_2000, 32'h0};
	int fails = 0;
	int compares = 0;

	always #2 CORE_CLK = ~CORE_CLK;

	uhr_operational_regs #(.WIN_BITS(WB)) dut (.CORE_CLK, .NRST, .BUS_ADDR, .BUS_WR, .BUS_RD, .BUS_BE,
		.BUS_WDATA, .CFG_FUNC, .CFG_WR, .CFG_RD, .OHCI0_EVENT, .OHCI1_EVENT, .EHCI_EVENT, .BUS_RDATA,
		.BUS_ACK, .EHCI_RUN, .EHCI_CONFIGURED);
	uhr_host_model host (.CORE_CLK, .BUS_RDATA, .BUS_ACK, .BUS_ADDR, .BUS_WR, .BUS_RD, .BUS_BE,
		.BUS_WDATA, .CFG_FUNC, .CFG_WR, .CFG_RD);

	task automatic wrap_up();
		if (fails == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one access; a missing answer that was due ends the run
	task automatic acc(input logic [2:0] k, input logic [1:0] f, input logic [11:0] o, input logic [31:0] d,
		input logic [3:0] b, input logic ea, input logic [31:0] ed);
		logic [31:0] q;
		logic g;
		host.xfer(k, bases[f] + {20'h0, o}, d, b, f, q, g);
		chk({31'h0, g}, {31'h0, ea});
		if (g !== ea && ea) wrap_up();
		if (k[0] && ea) chk(q, ed);
	endtask
	task automatic mrd(input logic [1:0] f, input logic [11:0] o, input logic [31:0] e);
		acc(3'h1, f, o, 32'h0, 4'hf, 1'b1, e);
	endtask
	task automatic mwr(input logic [1:0] f, input logic [11:0] o, input logic [31:0] d, input logic [3:0] b);
		acc(3'h2, f, o, d, b, 1'b1, 32'h0);
	endtask
	task automatic t_windows();
		for (int f = 0; f < 3; f++) begin
			acc(3'h6, f[1:0], 12'h0, 32'hffff_ffff, 4'hf, 1'b1, 32'h0);
			acc(3'h5, f[1:0], 12'h0, 32'h0, 4'hf, 1'b1, ~((32'h1 << WB) - 32'h1));
			acc(3'h6, f[1:0], 12'h0, bases[f], 4'hf, 1'b1, 32'h0);
			acc(3'h5, f[1:0], 12'h0, 32'h0, 4'hf, 1'b1, bases[f]);
		end
	endtask
	task automatic t_resets();
		logic [11:0] fo[8] = '{12'h000, 12'h004, 12'h034, 12'h044, 12'h048, 12'h04c, 12'h054, 12'h058};
		logic [31:0] fv[8] = '{32'h10, 32'h0, 32'h2edf, 32'h628, 32'hff00_0901, 32'h2_0000, 32'h0, 32'h0};
		logic [11:0] eo[8] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h020, 12'h024, 12'h028};
		logic [31:0] ev[8] = '{32'h0100_0020, 32'h2192, 32'h12, 32'h10, 32'h0, 32'h8_0000, 32'h1000, 32'h0};
		for (int i = 0; i < 8; i++) mrd(2'h0, fo[i], fv[i]);
		for (int i = 0; i < 8; i++) mrd(2'h1, fo[i], fv[i]);
		for (int i = 0; i < 8; i++) mrd(2'h2, eo[i], ev[i]);
	endtask
	task automatic t_readonly();
		logic [1:0] rf[5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2};
		logic [11:0] ro[5] = '{12'h000, 12'h058, 12'h000, 12'h014, 12'h06c};
		logic [31:0] rv[5] = '{32'h10, 32'h0, 32'h0100_0020, 32'h0, 32'h0};
		for (int i = 0; i < 5; i++) begin
			mwr(rf[i], ro[i], 32'hffff_ffff, 4'hf);
			mrd(rf[i], ro[i], rv[i]);
		end
	endtask
	task automatic t_rw();
		mwr(2'h1, 12'h034, 32'haaaa_5555, 4'h3);
		mrd(2'h1, 12'h034, 32'h5555);
		mrd(2'h0, 12'h034, 32'h2edf);
		mwr(2'h2, 12'h020, 32'h8_0001, 4'hf);
		mwr(2'h2, 12'h060, 32'h1, 4'hf);
		chk({30'h0, EHCI_RUN, EHCI_CONFIGURED}, 32'h3);
		mrd(2'h2, 12'h020, 32'h8_0001);
		mrd(2'h2, 12'h024, 32'h0);
	endtask
	// event pulses land in the flag words; a written one clears
	task automatic t_events();
		@(posedge CORE_CLK);
		OHCI0_EVENT <= 7'h04;
		OHCI1_EVENT <= 7'h40;
		EHCI_EVENT <= 6'h02;
		@(posedge CORE_CLK);
		{OHCI0_EVENT, OHCI1_EVENT, EHCI_EVENT} <= 20'h0;
		mrd(2'h0, 12'h00c, 32'h4);
		mrd(2'h1, 12'h00c, 32'h40);
		mrd(2'h2, 12'h024, 32'h2);
		mwr(2'h0, 12'h00c, 32'h4, 4'hf);
		mrd(2'h0, 12'h00c, 32'h0);
	endtask
	task automatic t_unmapped();
		acc(3'h1, 2'h3, 12'h000, 32'h0, 4'hf, 1'b0, 32'h0);
		acc(3'h2, 2'h3, 12'h034, 32'h1, 4'hf, 1'b0, 32'h0);
	endtask
	// mid-run reset: bases return to zero, so function 0 answers at zero
	task automatic t_reset2();
		@(posedge CORE_CLK);
		NRST <= 1'b0;
		repeat (2) @(posedge CORE_CLK);
		NRST <= 1'b1;
		@(posedge CORE_CLK);
		chk({30'h0, EHCI_RUN, EHCI_CONFIGURED}, 32'h0);
		mrd(2'h3, 12'h034, 32'h2edf);
		mrd(2'h3, 12'h000, 32'h10);
	endtask

	initial begin
		repeat (4) @(posedge CORE_CLK);
		NRST <= 1'b1;
		t_windows();
		t_resets();
		t_readonly();
		t_rw();
		t_events();
		t_unmapped();
		t_reset2();
		wrap_up();
	end
endmodule // test_usb_host_operational_regs

// ---- uhr_host_model.sv ----
/*
 * Host software model: issues memory and config cycles as one-cycle strobes.
 * Assumes the bank answers within eight cycles or not at all.
 */
`timescale 1ns/10ps
module uhr_host_model
	import uhr_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic [31:0] BUS_RDATA,
	input wire logic BUS_ACK,
	output logic [31:0] BUS_ADDR = 32'h0,
	output logic BUS_WR = 1'b0,
	output logic BUS_RD = 1'b0,
	output logic [3:0] BUS_BE = 4'h0,
	output logic [31:0] BUS_WDATA = 32'h0,
	output logic [1:0] CFG_FUNC = 2'h0,
	output logic CFG_WR = 1'b0,
	output logic CFG_RD = 1'b0
);
	// k: bit 0 read, bit 1 write, bit 2 config instead of memory
	task automatic xfer(input logic [2:0] k, input logic [31:0] a, input logic [31:0] d, input logic [3:0] be,
		input logic [1:0] f, output logic [31:0] q, output logic got);
		@(posedge CORE_CLK);
		BUS_ADDR <= a;
		BUS_WDATA <= d;
		BUS_BE <= be;
		CFG_FUNC <= f;
		BUS_RD <= k[0] & ~k[2];
		BUS_WR <= k[1] & ~k[2];
		CFG_RD <= k[0] & k[2];
		CFG_WR <= k[1] & k[2];
		@(posedge CORE_CLK);
		{BUS_RD, BUS_WR, CFG_RD, CFG_WR} <= 4'h0;
		got = 1'b0;
		q = 32'h0;
		for (int n = 0; n < 8 && !got; n++) begin
			@(posedge CORE_CLK);
			got = BUS_ACK === 1'b1;
			q = BUS_RDATA;
		end
		// released lines show garbage, not the last value
		BUS_ADDR <= ~a;
		BUS_WDATA <= ~d;
	endtask
endmodule // uhr_host_model

// ---- uhr_operational_regs.sv ----
/*
 * Operational register bank of the three host controller functions: two
 * full-speed functions with one root port each and one high-speed function.
 * Holds the window base registers, address decode, reset values and the
 * read-only capability group.
 * Assumes an upstream bus target that turns memory and configuration cycles
 * into one-cycle strobes on the core clock, and list engines on the same clock
 * that pulse event inputs.
 * Limitations: list engines, frame timers and root-hub signalling live
 * elsewhere; the words they own read back zero or what software last wrote.
 * Window bases all reset to zero, so the three windows overlap until
 * configuration moves them apart; the lowest function answers meanwhile.
 * Memory cycles outside every window get no answer at all, so the upstream
 * target must time them out and abort the cycle itself.
 */
// What this block does
// - each function's registers are plain uncached memory-mapped words
// - window base register's fixed low bits report the window size
// - registers answer at programmed base plus fixed offset
// - full-speed functions carry operational registers only, no capability group
// - high-speed function has read-only capability group then operational group
// - revision register read-only, bits 31:8 zero, low byte resets 0x10
// - frame interval register resets to 0x00002edf in both full-speed functions
// - low-speed threshold resets to 0x00000628 in both full-speed functions
// - second root-hub descriptor resets to 0x00020000 in both full-speed functions
// - full-speed functions have only one root port register; offset 0x58 unimplemented
// - revision low byte is interface version in BCD, 0x10 means 1.0
`timescale 1ns/10ps

module uhr_operational_regs
	import uhr_pkg::*;
#(
	parameter int unsigned WIN_BITS = WIN_BITS_DEFAULT
) (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic [31:0] BUS_ADDR,
	input wire logic BUS_WR,
	input wire logic BUS_RD,
	input wire logic [3:0] BUS_BE,
	input wire logic [31:0] BUS_WDATA,
	input wire logic [1:0] CFG_FUNC,
	input wire logic CFG_WR,
	input wire logic CFG_RD,
	input wire logic [6:0] OHCI0_EVENT,
	input wire logic [6:0] OHCI1_EVENT,
	input wire logic [5:0] EHCI_EVENT,
	output logic [31:0] BUS_RDATA,
	output logic BUS_ACK,
	output logic EHCI_RUN,
	output logic EHCI_CONFIGURED
);

	// window must hold every offset and stay word aligned
	// below 12 bits the twelve-bit offset would reach into the base bits,
	// above 31 the base register would have no writable bit left
	initial begin
		if (WIN_BITS < 12 || WIN_BITS > 31) begin
			$error("WIN_BITS must lie between 12 and 31");
		end
	end

	// upper bits writable, lower bits read zero to report size
	// software writes all ones and reads back this mask to learn the size,
	// so the mask must never be widened by a stray write
	localparam logic [31:0] BAR_MASK = ~((32'h1 << WIN_BITS) - 32'h1);

	uhr_state_type st_reg;
	uhr_state_type st_next;

	// byte-lane merge of a write into a stored word
	// every writable word goes through here, so partial writes behave
	// the same on all three functions; lanes not enabled keep old bytes
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// bits of the write data that its byte enables cover
	function automatic logic [31:0] be_bits(input logic [31:0] wd, input logic [3:0] be);
		return be_merge(32'h0, wd, be);
	endfunction

	// full-speed read mux; capability offsets do not exist here
	// words owned by the list engines and frame timers read zero here,
	// since those engines sit outside this bank
	function automatic logic [31:0] ohci_read(input uhr_ohci_type o, input logic [11:0] off);
		logic [31:0] r;
		r = 32'h0;
		unique case (off)
			OFS_OHCI_SPEC_REVISION: r = RST_OHCI_SPEC_REVISION;
			// control and status group
			OFS_OHCI_OPERATING_MODE: r = o.mode;
			OFS_OHCI_COMMAND_STATE: r = o.cmd;
			OFS_OHCI_EVENT_FLAGS: r = o.evt;
			OFS_OHCI_EVENT_MASK_SET: r = o.mask;
			OFS_OHCI_EVENT_MASK_CLEAR: r = o.mask;
			// memory pointer group
			OFS_OHCI_COMM_AREA_POINTER: r = o.hcca;
			OFS_OHCI_PERIODIC_CURRENT_DESC: r = 32'h0;
			OFS_OHCI_CONTROL_LIST_HEAD: r = o.ctl_head;
			OFS_OHCI_CONTROL_LIST_CURRENT: r = o.ctl_cur;
			OFS_OHCI_BULK_LIST_HEAD: r = o.blk_head;
			OFS_OHCI_BULK_LIST_CURRENT: r = o.blk_cur;
			OFS_OHCI_DONE_QUEUE_HEAD: r = 32'h0;
			// frame counter group; remaining and count belong to the frame timer
			OFS_OHCI_FRAME_INTERVAL: r = o.fm_intv;
			OFS_OHCI_FRAME_REMAINING: r = 32'h0;
			OFS_OHCI_FRAME_COUNT: r = 32'h0;
			OFS_OHCI_PERIODIC_START_POINT: r = o.per_start;
			OFS_OHCI_LOW_SPEED_THRESHOLD: r = o.ls_thr;
			// root hub group, one port only
			OFS_OHCI_ROOT_HUB_DESC_A: r = o.rh_a;
			OFS_OHCI_ROOT_HUB_DESC_B: r = o.rh_b;
			OFS_OHCI_ROOT_HUB_STATE: r = o.rh_st;
			OFS_OHCI_ROOT_PORT1_STATE: r = o.port1;
			OFS_OHCI_ROOT_PORT2_STATE: r = 32'h0;
			default: r = 32'h0;
		endcase
		return r;
	endfunction

	// high-speed read mux: fixed capability words, then operational words
	// capability words come from constants, so no write can ever reach them
	function automatic logic [31:0] ehci_read(input uhr_ehci_type e, input logic [11:0] off);
		logic [31:0] r;
		r = 32'h0;
		unique case (off)
			OFS_EHCI_CAP_LENGTH_VERSION: r = RST_EHCI_CAP_LENGTH_VERSION;
			OFS_EHCI_STRUCTURAL_PARAMS: r = RST_EHCI_STRUCTURAL_PARAMS;
			OFS_EHCI_CAPABILITY_PARAMS: r = RST_EHCI_CAPABILITY_PARAMS;
			OFS_EHCI_COMPANION_ROUTE_LOW: r = RST_EHCI_COMPANION_ROUTE_LOW;
			OFS_EHCI_COMPANION_ROUTE_HIGH: r = RST_EHCI_COMPANION_ROUTE_HIGH;
			// operational group
			OFS_EHCI_RUN_COMMAND: r = e.cmd;
			OFS_EHCI_RUN_STATE: r = e.sts;
			OFS_EHCI_EVENT_MASK: r = e.intr;
			OFS_EHCI_MICROFRAME_INDEX: r = e.ehci_microframe_index;
			OFS_EHCI_PERIODIC_LIST_BASE: r = e.plist;
			OFS_EHCI_ASYNC_LIST_ADDRESS: r = e.alist;
			OFS_EHCI_CONFIGURED_FLAG: r = e.cfgflag;
			OFS_EHCI_PORT1_CONTROL: r = e.ehci_port1_control;
			OFS_EHCI_PORT2_CONTROL: r = e.ehci_port2_control;
			default: r = 32'h0;
		endcase
		return r;
	endfunction

	// full-speed write: read-only words and reserved offsets drop the write
	// mixed-access words are kept as plain storage; their per-bit actions
	// belong to the engines that use them
	function automatic uhr_ohci_type ohci_write(input uhr_ohci_type o, input logic [11:0] off,
		input logic [31:0] wd, input logic [3:0] be);
		uhr_ohci_type n;
		n = o;
		unique case (off)
			OFS_OHCI_OPERATING_MODE: n.mode = be_merge(o.mode, wd, be);
			OFS_OHCI_COMMAND_STATE: n.cmd = be_merge(o.cmd, wd, be);
			// flags clear on written ones; the mask has separate set and clear words
			OFS_OHCI_EVENT_FLAGS: n.evt = o.evt & ~(be_bits(wd, be) & OHCI_EVENT_W1C_MASK);
			OFS_OHCI_EVENT_MASK_SET: n.mask = o.mask | be_bits(wd, be);
			OFS_OHCI_EVENT_MASK_CLEAR: n.mask = o.mask & ~be_bits(wd, be);
			// pointers and thresholds are plain storage
			OFS_OHCI_COMM_AREA_POINTER: n.hcca = be_merge(o.hcca, wd, be);
			OFS_OHCI_CONTROL_LIST_HEAD: n.ctl_head = be_merge(o.ctl_head, wd, be);
			OFS_OHCI_CONTROL_LIST_CURRENT: n.ctl_cur = be_merge(o.ctl_cur, wd, be);
			OFS_OHCI_BULK_LIST_HEAD: n.blk_head = be_merge(o.blk_head, wd, be);
			OFS_OHCI_BULK_LIST_CURRENT: n.blk_cur = be_merge(o.blk_cur, wd, be);
			OFS_OHCI_FRAME_INTERVAL: n.fm_intv = be_merge(o.fm_intv, wd, be);
			OFS_OHCI_PERIODIC_START_POINT: n.per_start = be_merge(o.per_start, wd, be);
			OFS_OHCI_LOW_SPEED_THRESHOLD: n.ls_thr = be_merge(o.ls_thr, wd, be);
			OFS_OHCI_ROOT_HUB_DESC_A: n.rh_a = be_merge(o.rh_a, wd, be);
			OFS_OHCI_ROOT_HUB_DESC_B: n.rh_b = be_merge(o.rh_b, wd, be);
			OFS_OHCI_ROOT_HUB_STATE: n.rh_st = be_merge(o.rh_st, wd, be);
			OFS_OHCI_ROOT_PORT1_STATE: n.port1 = be_merge(o.port1, wd, be);
			default: n = o;
		endcase
		return n;
	endfunction

	// high-speed write: capability group never changes
	// status low bits clear on written ones; halted is rebuilt every cycle
	function automatic uhr_ehci_type ehci_write(input uhr_ehci_type e, input logic [11:0] off,
		input logic [31:0] wd, input logic [3:0] be);
		uhr_ehci_type n;
		n = e;
		unique case (off)
			OFS_EHCI_RUN_COMMAND: n.cmd = be_merge(e.cmd, wd, be);
			OFS_EHCI_RUN_STATE: n.sts = e.sts & ~(be_bits(wd, be) & EHCI_STATE_W1C_MASK);
			OFS_EHCI_EVENT_MASK: n.intr = be_merge(e.intr, wd, be);
			OFS_EHCI_MICROFRAME_INDEX: n.ehci_microframe_index = be_merge(e.ehci_microframe_index, wd, be);
			OFS_EHCI_PERIODIC_LIST_BASE: n.plist = be_merge(e.plist, wd, be);
			OFS_EHCI_ASYNC_LIST_ADDRESS: n.alist = be_merge(e.alist, wd, be);
			OFS_EHCI_CONFIGURED_FLAG: n.cfgflag = be_merge(e.cfgflag, wd, be);
			OFS_EHCI_PORT1_CONTROL: n.ehci_port1_control = be_merge(e.ehci_port1_control, wd, be);
			OFS_EHCI_PORT2_CONTROL: n.ehci_port2_control = be_merge(e.ehci_port2_control, wd, be);
			default: n = e;
		endcase
		return n;
	endfunction

	// reset image of one full-speed function
	// only constants here, so the asynchronous reset branch stays clean;
	// words not named below reset to zero
	function automatic uhr_ohci_type ohci_reset();
		uhr_ohci_type o;
		o = '0;
		o.fm_intv = RST_OHCI_FRAME_INTERVAL;
		o.ls_thr = RST_OHCI_LOW_SPEED_THRESHOLD;
		o.rh_a = RST_OHCI_ROOT_HUB_DESC_A;
		o.rh_b = RST_OHCI_ROOT_HUB_DESC_B;
		return o;
	endfunction

	// decode results, one hit bit per function window
	logic [2:0] hit;
	logic [1:0] sel;
	logic any_hit;
	logic [11:0] off;
	logic in_regs;
	// read word and event inputs gathered for indexing
	logic [31:0] rd_word;
	logic [6:0] ohci_evt [2];

	// window decode; lowest function wins while bases still overlap at zero
	// the offset is taken from the low twelve address bits only; larger
	// windows mark everything past the first 4 KB as reserved space,
	// which then answers with zero and swallows writes
	always_comb begin
		for (int f = 0; f < 3; f++) begin
			hit[f] = ((BUS_ADDR & BAR_MASK) == st_reg.bar[f]);
		end
		any_hit = |hit;
		sel = hit[0] ? FUNC_OHCI0 : (hit[1] ? FUNC_OHCI1 : FUNC_EHCI);
		off = BUS_ADDR[11:0];
		// offsets past the register block but inside the window are reserved
		in_regs = ((BUS_ADDR & ~BAR_MASK & 32'hffff_f000) == 32'h0);
	end

	// read data of the addressed word, zero for reserved space
	// computed every cycle; only latched when a read is taken
	always_comb begin
		ohci_evt[0] = OHCI0_EVENT;
		ohci_evt[1] = OHCI1_EVENT;
		rd_word = 32'h0;
		if (in_regs) begin
			if (sel == FUNC_EHCI) begin
				rd_word = ehci_read(st_reg.ehci, off);
			end else begin
				rd_word = ohci_read(st_reg.ohci[sel[0]], off);
			end
		end
	end

	// next state: bus writes, config writes, then hardware events on top
	// memory cycles that hit a window win over config cycles in the same clock; the config
	// cycle is then dropped unanswered, so the upstream target must retry.
	// a read wins over a write when both strobes are high
	always_comb begin
		st_next = st_reg;
		st_next.ack = 1'b0;
		st_next.rdata = 32'h0;
		// plain word accesses, no side effect on reads, so uncached use is safe
		if ((BUS_WR || BUS_RD) && any_hit) begin
			st_next.ack = 1'b1;
			if (BUS_RD) begin
				st_next.rdata = rd_word;
			end else if (in_regs) begin
				if (sel == FUNC_EHCI) begin
					st_next.ehci = ehci_write(st_reg.ehci, off, BUS_WDATA, BUS_BE);
				end else begin
					st_next.ohci[sel[0]] = ohci_write(st_reg.ohci[sel[0]], off, BUS_WDATA, BUS_BE);
				end
			end
		end else if ((CFG_WR || CFG_RD) && CFG_FUNC <= FUNC_EHCI) begin
			st_next.ack = 1'b1;
			if (CFG_RD) begin
				st_next.rdata = st_reg.bar[CFG_FUNC];
			end else begin
				// size bits and flag bits stay zero whatever is written
				st_next.bar[CFG_FUNC] = be_merge(st_reg.bar[CFG_FUNC], BUS_WDATA, BUS_BE) & BAR_MASK;
			end
		end
		// set wins over a clear in the same cycle
		for (int f = 0; f < 2; f++) begin
			st_next.ohci[f].evt = st_next.ohci[f].evt | {25'h0, ohci_evt[f]};
		end
		st_next.ehci.sts = st_next.ehci.sts | {26'h0, EHCI_EVENT};
		// halted tracks the run bit with one cycle of lag
		st_next.ehci.sts[EHCI_HALTED_BIT] = ~st_reg.ehci.cmd[EHCI_RUN_BIT];
		st_next.run = st_next.ehci.cmd[EHCI_RUN_BIT];
		st_next.cfg = st_next.ehci.cfgflag[0];
	end

	// single state register with constant reset image
	// window bases return to zero here, so software must configure again
	// after every reset before the windows separate
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			st_reg <= '0;
			st_reg.ohci[0] <= ohci_reset();
			st_reg.ohci[1] <= ohci_reset();
			st_reg.ehci.cmd <= RST_EHCI_RUN_COMMAND;
			st_reg.ehci.sts <= RST_EHCI_RUN_STATE;
			st_reg.bar <= {3{BAR_MASK & 32'h0 | {28'h0, BAR_MEM_FLAGS}}};
		end else begin
			st_reg <= st_next;
		end
	end

	// every output is a field of the state register, no logic after it;
	// read data is zero outside an answer so the upstream mux can or-combine
	assign BUS_RDATA = st_reg.rdata;
	assign BUS_ACK = st_reg.ack;
	assign EHCI_RUN = st_reg.run;
	assign EHCI_CONFIGURED = st_reg.cfg;

endmodule // uhr_operational_regs

// ---- uhr_operational_regs_chk.sv ----
/*
 * Port checker for the operational register bank.
 * Assumes one core clock, active-low async reset, function 0 winning window overlaps.
 */
`timescale 1ns/10ps
module uhr_regs_chk
	import uhr_pkg::*;
#(
	parameter int unsigned WIN_BITS = WIN_BITS_DEFAULT
) (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic [31:0] BUS_ADDR,
	input wire logic BUS_WR,
	input wire logic BUS_RD,
	input wire logic [3:0] BUS_BE,
	input wire logic [31:0] BUS_WDATA,
	input wire logic [1:0] CFG_FUNC,
	input wire logic CFG_WR,
	input wire logic CFG_RD,
	input wire logic [31:0] BUS_RDATA,
	input wire logic BUS_ACK,
	input wire logic EHCI_RUN,
	input wire logic EHCI_CONFIGURED
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);
	logic [31:0] keep_mask;
	logic [31:0] base0_reg;
	logic hit0;
	// shadow of the function 0 base; a memory cycle in the same cycle drops the config write
	assign keep_mask = ~((32'h1 << WIN_BITS) - 32'h1);
	assign hit0 = BUS_RD && ((BUS_ADDR & keep_mask) == base0_reg);
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			base0_reg <= 32'h0;
		end else if (CFG_WR && CFG_FUNC == FUNC_OHCI0 && !BUS_RD && !BUS_WR) begin
			for (int i = 0; i < 4; i++) begin
				if (BUS_BE[i]) begin
					base0_reg[8*i +: 8] <= BUS_WDATA[8*i +: 8] & keep_mask[8*i +: 8];
				end
			end
		end
	end
	property p_ack_cause;
		BUS_ACK |-> $past(BUS_RD || BUS_WR || CFG_RD || CFG_WR);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("answer without a request");
	property p_idle_zero;
		!BUS_ACK |-> BUS_RDATA == 32'h0;
	endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("read data outside an answer");
	property p_wr_zero;
		BUS_ACK && $past(BUS_WR && !BUS_RD) |-> BUS_RDATA == 32'h0;
	endproperty
	a_wr_zero: assert property (p_wr_zero) else $error("read data on a write answer");
	property p_rst_quiet;
		$past(!NRST) |-> !BUS_ACK && !EHCI_RUN && !EHCI_CONFIGURED;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
	property p_run_src;
		$changed(EHCI_RUN) |-> $past(BUS_WR);
	endproperty
	a_run_src: assert property (p_run_src) else $error("run level moved without a write");
	property p_conf_src;
		$changed(EHCI_CONFIGURED) |-> $past(BUS_WR);
	endproperty
	a_conf_src: assert property (p_conf_src) else $error("configured level moved without a write");
	property p_f0_ack;
		hit0 |=> BUS_ACK;
	endproperty
	a_f0_ack: assert property (p_f0_ack) else $error("window read not answered");
	property p_f0_rev;
		hit0 && BUS_ADDR[11:0] == 12'h000 ##1 1'b1 |-> BUS_RDATA == 32'h0000_0010;
	endproperty
	a_f0_rev: assert property (p_f0_rev) else $error("revision word wrong");
	property p_f0_hole;
		hit0 && BUS_ADDR[11:0] == 12'h058 |=> BUS_RDATA == 32'h0;
	endproperty
	a_f0_hole: assert property (p_f0_hole) else $error("second port word not zero");
endmodule // uhr_regs_chk

bind uhr_operational_regs uhr_regs_chk #(.WIN_BITS(WIN_BITS)) chk (.CORE_CLK, .NRST, .BUS_ADDR, .BUS_WR,
	.BUS_RD, .BUS_BE, .BUS_WDATA, .CFG_FUNC, .CFG_WR, .CFG_RD, .BUS_RDATA, .BUS_ACK, .EHCI_RUN, .EHCI_CONFIGURED);

// ---- uhr_pkg.sv ----
/*
 * Shared constants and types for the host controller operational register bank:
 * register offsets, reset values, function numbers and the state carriers.
 * Assumes a single core clock domain and 32-bit word accesses with byte enables.
 */
package uhr_pkg;

	// function numbers on the configuration side
	localparam logic [1:0] FUNC_OHCI0 = 2'h0;
	localparam logic [1:0] FUNC_OHCI1 = 2'h1;
	localparam logic [1:0] FUNC_EHCI = 2'h2;

	// low bits of the window base register: 32-bit, non-prefetchable memory
	localparam logic [3:0] BAR_MEM_FLAGS = 4'h0;
	localparam int unsigned WIN_BITS_DEFAULT = 12;

	// full-speed function offsets
	localparam logic [11:0] OFS_OHCI_SPEC_REVISION = 12'h000;
	localparam logic [11:0] OFS_OHCI_OPERATING_MODE = 12'h004;
	localparam logic [11:0] OFS_OHCI_COMMAND_STATE = 12'h008;
	localparam logic [11:0] OFS_OHCI_EVENT_FLAGS = 12'h00c;
	localparam logic [11:0] OFS_OHCI_EVENT_MASK_SET = 12'h010;
	localparam logic [11:0] OFS_OHCI_EVENT_MASK_CLEAR = 12'h014;
	localparam logic [11:0] OFS_OHCI_COMM_AREA_POINTER = 12'h018;
	localparam logic [11:0] OFS_OHCI_PERIODIC_CURRENT_DESC = 12'h01c;
	localparam logic [11:0] OFS_OHCI_CONTROL_LIST_HEAD = 12'h020;
	localparam logic [11:0] OFS_OHCI_CONTROL_LIST_CURRENT = 12'h024;
	localparam logic [11:0] OFS_OHCI_BULK_LIST_HEAD = 12'h028;
	localparam logic [11:0] OFS_OHCI_BULK_LIST_CURRENT = 12'h02c;
	localparam logic [11:0] OFS_OHCI_DONE_QUEUE_HEAD = 12'h030;
	localparam logic [11:0] OFS_OHCI_FRAME_INTERVAL = 12'h034;
	localparam logic [11:0] OFS_OHCI_FRAME_REMAINING = 12'h038;
	localparam logic [11:0] OFS_OHCI_FRAME_COUNT = 12'h03c;
	localparam logic [11:0] OFS_OHCI_PERIODIC_START_POINT = 12'h040;
	localparam logic [11:0] OFS_OHCI_LOW_SPEED_THRESHOLD = 12'h044;
	localparam logic [11:0] OFS_OHCI_ROOT_HUB_DESC_A = 12'h048;
	localparam logic [11:0] OFS_OHCI_ROOT_HUB_DESC_B = 12'h04c;
	localparam logic [11:0] OFS_OHCI_ROOT_HUB_STATE = 12'h050;
	localparam logic [11:0] OFS_OHCI_ROOT_PORT1_STATE = 12'h054;
	localparam logic [11:0] OFS_OHCI_ROOT_PORT2_STATE = 12'h058;

	// high-speed function offsets
	localparam logic [11:0] OFS_EHCI_CAP_LENGTH_VERSION = 12'h000;
	localparam logic [11:0] OFS_EHCI_STRUCTURAL_PARAMS = 12'h004;
	localparam logic [11:0] OFS_EHCI_CAPABILITY_PARAMS = 12'h008;
	localparam logic [11:0] OFS_EHCI_COMPANION_ROUTE_LOW = 12'h00c;
	localparam logic [11:0] OFS_EHCI_COMPANION_ROUTE_HIGH = 12'h010;
	localparam logic [11:0] OFS_EHCI_RUN_COMMAND = 12'h020;
	localparam logic [11:0] OFS_EHCI_RUN_STATE = 12'h024;
	localparam logic [11:0] OFS_EHCI_EVENT_MASK = 12'h028;
	localparam logic [11:0] OFS_EHCI_MICROFRAME_INDEX = 12'h02c;
	localparam logic [11:0] OFS_EHCI_PERIODIC_LIST_BASE = 12'h034;
	localparam logic [11:0] OFS_EHCI_ASYNC_LIST_ADDRESS = 12'h038;
	localparam logic [11:0] OFS_EHCI_CONFIGURED_FLAG = 12'h060;
	localparam logic [11:0] OFS_EHCI_PORT1_CONTROL = 12'h064;
	localparam logic [11:0] OFS_EHCI_PORT2_CONTROL = 12'h068;

	// reset values
	localparam logic [31:0] RST_OHCI_SPEC_REVISION = 32'h0000_0010;
	localparam logic [31:0] RST_OHCI_FRAME_INTERVAL = 32'h0000_2edf;
	localparam logic [31:0] RST_OHCI_LOW_SPEED_THRESHOLD = 32'h0000_0628;
	localparam logic [31:0] RST_OHCI_ROOT_HUB_DESC_A = 32'hff00_0901;
	localparam logic [31:0] RST_OHCI_ROOT_HUB_DESC_B = 32'h0002_0000;
	localparam logic [31:0] RST_EHCI_CAP_LENGTH_VERSION = 32'h0100_0020;
	localparam logic [31:0] RST_EHCI_STRUCTURAL_PARAMS = 32'h0000_2192;
	localparam logic [31:0] RST_EHCI_CAPABILITY_PARAMS = 32'h0000_0012;
	localparam logic [31:0] RST_EHCI_COMPANION_ROUTE_LOW = 32'h0000_0010;
	localparam logic [31:0] RST_EHCI_COMPANION_ROUTE_HIGH = 32'h0000_0000;
	localparam logic [31:0] RST_EHCI_RUN_COMMAND = 32'h0008_0000;
	localparam logic [31:0] RST_EHCI_RUN_STATE = 32'h0000_1000;

	// field positions
	localparam int unsigned EHCI_RUN_BIT = 0;
	localparam int unsigned EHCI_HALTED_BIT = 12;
	localparam logic [31:0] EHCI_STATE_W1C_MASK = 32'h0000_003f;
	localparam logic [31:0] OHCI_EVENT_W1C_MASK = 32'h0000_007f;

	typedef struct packed {
		logic [31:0] mode;
		logic [31:0] cmd;
		logic [31:0] evt;
		logic [31:0] mask;
		logic [31:0] hcca;
		logic [31:0] ctl_head;
		logic [31:0] ctl_cur;
		logic [31:0] blk_head;
		logic [31:0] blk_cur;
		logic [31:0] fm_intv;
		logic [31:0] per_start;
		logic [31:0] ls_thr;
		logic [31:0] rh_a;
		logic [31:0] rh_b;
		logic [31:0] rh_st;
		logic [31:0] port1;
	} uhr_ohci_type;

	typedef struct packed {
		logic [31:0] cmd;
		logic [31:0] sts;
		logic [31:0] intr;
		logic [31:0] ehci_microframe_index;
		logic [31:0] plist;
		logic [31:0] alist;
		logic [31:0] cfgflag;
		logic [31:0] ehci_port1_control;
		logic [31:0] ehci_port2_control;
	} uhr_ehci_type;

	typedef struct packed {
		uhr_ohci_type [1:0] ohci;
		uhr_ehci_type ehci;
		logic [2:0][31:0] bar;
		logic [31:0] rdata;
		logic ack;
		logic run;
		logic cfg;
	} uhr_state_type;

endpackage
